// ---- ssc_channel.sv ----
// How it works
// - prescaler zero passes, else divide 2n
// - overrun sets flag in receive buffer
// - overrun frame raises no receive request
// - direction bit picks internal or external
// - source field feeds eight-bit rate divisor
// - flow control enable and CTS/RTS choice
// - shift register empty status readable
// - data output push-pull or open drain
// - polarity bit picks launch/sample edges
// - LSB or MSB first, both directions
// - no transfer without transmit enable
// - accept frames only with receive enable
// - buffer empty flag tracks written data
// - transmit request on load or completion
// - continuous receive read refills buffer flag
// - inversion on output and received data
// - clock pin output format select
// - start needs enable, data, and CTS low when CTS flow control is used
// - completed frame sets receive complete
// - overrun at seventh bit before read
// - driven clock idles per polarity
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`include "ssc_consts.svh"
module ssc_channel
  import ssc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [31:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [31:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire ssc_pkg::ssc_pin_in_t  pin_in,
  output ssc_pkg::ssc_pin_out_t      pin_out,
  output logic                       tx_int_pulse,
  output logic                       rx_int_pulse
);
  import ssc_pkg::*;
  logic [7:0]  tx_buffer_r;
  logic [7:0]  rx_buffer_r;
  logic [7:0]  bit_rate_divisor_r;
  logic [7:0]  serial_mode_config_r;
  logic [7:0]  ctla_r;
  logic [7:0]  ctlb_r;
  logic [7:0]  smr1_r;
  logic [7:0]  smr2_r;
  logic [7:0]  smr3_r;
  logic [7:0]  smr4_r;
  logic [3:0]  prescale_setting_r;
  logic        overrun_flag_r;
  logic        rx_complete_r;
  logic        tx_buffer_empty_r;
  logic        tx_shift_empty_r;
  logic [2:0]  clk_sync_r;
  logic [1:0]  rxd_sync_r;
  logic [1:0]  cts_sync_r;
  logic        half_tick;
  logic        clk_int_r;
  logic        ext_rise;
  logic        ext_fall;
  logic        rise_ev;
  logic        fall_ev;
  logic        launch_ev;
  logic        sample_ev;
  ssc_state_t  state_r;
  logic [7:0]  tsh_r;
  logic [7:0]  rsh_r;
  logic [3:0]  bit_cnt_r;
  logic        rx_ok_r;
  logic        txd_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        wr_fire;
  logic        rd_fire;
  logic        rd_rxbuf;
  logic        start_ok;
  logic        clock_source_dir;
  logic        edge_polarity_sel;
  logic        msb_first;
  logic        inv;
  logic        tx_en;
  logic        rx_en;
  logic        cts_used;
  logic [7:0]  rx_bits;
  logic [7:0]  rd_word;
  logic        rd_hit;

  assign clock_source_dir     = serial_mode_config_r[`SSC_MODE_CLOCK_SOURCE_DIR];
  assign edge_polarity_sel     = ctla_r[`SSC_CA_EDGE_POLARITY_SEL];
  assign msb_first = ctla_r[`SSC_CA_BIT_ORDER_SEL];
  assign inv       = ctlb_r[`SSC_CB_LCH];
  assign tx_en     = ctlb_r[`SSC_CB_TE];
  // receive needs its own enable and transmit enable
  assign rx_en     = ctlb_r[`SSC_CB_RE] & tx_en;
  assign cts_used  = ~ctla_r[`SSC_CA_CRD] & ~ctla_r[`SSC_CA_CRS];

  ssc_rate_gen u_rate (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .prescale_setting (prescale_setting_r),
    .count_source_sel (ctla_r[1:0]),
    .bit_rate_divisor (bit_rate_divisor_r),
    .half_tick        (half_tick)
  );

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sync_r <= 3'h7;
      rxd_sync_r <= 2'h3;
      cts_sync_r <= 2'h3;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], pin_in.clk_i};
      rxd_sync_r <= {rxd_sync_r[0], pin_in.rxd_i};
      cts_sync_r <= {cts_sync_r[0], pin_in.cts_i};
    end
  end
  // peer idles clock per polarity, so no false edge
  assign ext_rise = clk_sync_r[1] & ~clk_sync_r[2];
  assign ext_fall = ~clk_sync_r[1] & clk_sync_r[2];

  // internal clock toggles only while shifting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_int_r <= 1'b1;
    end else if (state_r != SSC_SHIFT) begin
      clk_int_r <= ~edge_polarity_sel;
    end else if (half_tick) begin
      clk_int_r <= ~clk_int_r;
    end
  end
  // edges from internal clock or pin
  assign rise_ev = clock_source_dir ? ext_rise
                         : (state_r == SSC_SHIFT && half_tick && !clk_int_r);
  assign fall_ev = clock_source_dir ? ext_fall
                         : (state_r == SSC_SHIFT && half_tick && clk_int_r);
  // polarity picks launch and sample edges
  assign launch_ev = edge_polarity_sel ? rise_ev : fall_ev;
  assign sample_ev = edge_polarity_sel ? fall_ev : rise_ev;

  assign start_ok = tx_en && !tx_buffer_empty_r && (!cts_used || !cts_sync_r[1]);
  // received bit inverted, placed by order
  assign rx_bits = msb_first ? {rsh_r[6:0], rxd_sync_r[1] ^ inv}
                             : {rxd_sync_r[1] ^ inv, rsh_r[7:1]};

  // shift engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r      <= SSC_IDLE;
      tsh_r        <= 8'h00;
      rsh_r        <= 8'h00;
      bit_cnt_r    <= 4'h0;
      rx_ok_r      <= 1'b0;
      txd_r        <= 1'b1;
      tx_int_pulse <= 1'b0;
    end else begin
      tx_int_pulse <= 1'b0;
      case (state_r)
        SSC_IDLE: begin
          if (start_ok) begin
            tsh_r     <= inv ? ~tx_buffer_r : tx_buffer_r;
            bit_cnt_r <= 4'h0;
            rx_ok_r   <= rx_en;
            state_r   <= SSC_SHIFT;
            tx_int_pulse <= ~ctlb_r[`SSC_CB_IRS];
          end
        end
        SSC_SHIFT: begin
          if (!tx_en) begin
            state_r <= SSC_IDLE;
            txd_r   <= 1'b1;
          end else begin
            if (launch_ev) begin
              txd_r <= msb_first ? tsh_r[7] : tsh_r[0];
              tsh_r <= msb_first ? {tsh_r[6:0], 1'b0} : {1'b0, tsh_r[7:1]};
            end
            if (sample_ev) begin
              rsh_r     <= rx_bits;
              bit_cnt_r <= bit_cnt_r + 4'h1;
              // eight sample edges end the frame
              if (bit_cnt_r == `SSC_FRAME_BITS - 4'h1) begin
                state_r <= SSC_DONE;
              end
            end
          end
        end
        SSC_DONE: begin
          state_r <= SSC_IDLE;
          // line back to idle high, releases open drain
          txd_r   <= 1'b1;
          tx_int_pulse <= ctlb_r[`SSC_CB_IRS];
        end
        default: state_r <= SSC_IDLE;
      endcase
    end
  end

  // AXI write path, address and data in any order
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_got_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r  <= 1'b1;
        w_data_r <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r <= `SSC_A_PRESC && aw_addr_r[1:0] == 2'h0)
                        ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // plain configuration registers, low byte lane
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bit_rate_divisor_r   <= 8'h00;
      serial_mode_config_r <= 8'h00;
      ctla_r               <= `SSC_CA_RESET;
      smr1_r               <= 8'h00;
      smr2_r               <= 8'h00;
      smr3_r               <= 8'h00;
      smr4_r               <= 8'h00;
      prescale_setting_r   <= 4'h0;
      tx_buffer_r          <= 8'h00;
    end else if (wr_fire && s_axi_wstrb[0]) begin
      case (aw_addr_r)
        `SSC_A_TXBUF: tx_buffer_r          <= w_data_r[7:0];
        `SSC_A_BRG:   bit_rate_divisor_r   <= w_data_r[7:0];
        `SSC_A_MODE:  serial_mode_config_r <= w_data_r[7:0];
        `SSC_A_CTLA:  ctla_r               <= {w_data_r[7:4], 1'b0, w_data_r[2:0]};
        `SSC_A_SMR1:  smr1_r               <= w_data_r[7:0];
        `SSC_A_SMR2:  smr2_r               <= w_data_r[7:0];
        `SSC_A_SMR3:  smr3_r               <= w_data_r[7:0];
        `SSC_A_SMR4:  smr4_r               <= w_data_r[7:0];
        `SSC_A_PRESC: prescale_setting_r   <= w_data_r[3:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctlb_r <= 8'h00;
    end else if (wr_fire && s_axi_wstrb[0] && aw_addr_r == `SSC_A_CTLB) begin
      ctlb_r <= w_data_r[7:0];
    end
  end

  assign rd_rxbuf = rd_fire && s_axi_araddr[7:0] == `SSC_A_RXBUF;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buffer_empty_r <= 1'b1;
    end else if (wr_fire && s_axi_wstrb[0] && aw_addr_r == `SSC_A_TXBUF) begin
      tx_buffer_empty_r <= 1'b0;
    end else if (rd_rxbuf && ctlb_r[`SSC_CB_RRM]) begin
      tx_buffer_empty_r <= 1'b0;
    end else if (state_r == SSC_IDLE && start_ok) begin
      tx_buffer_empty_r <= 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_shift_empty_r <= 1'b1;
    end else begin
      tx_shift_empty_r <= (state_r == SSC_IDLE) && !start_ok;
    end
  end

  // receive buffer, complete and overrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buffer_r    <= 8'h00;
      rx_complete_r  <= 1'b0;
      overrun_flag_r <= 1'b0;
      rx_int_pulse   <= 1'b0;
    end else begin
      rx_int_pulse <= 1'b0;
      if (state_r == SSC_DONE && rx_ok_r) begin
        rx_buffer_r <= rsh_r;
        if (!overrun_flag_r) begin
          rx_complete_r <= 1'b1;
          rx_int_pulse  <= 1'b1;
        end
      end else if (rd_rxbuf) begin
        rx_complete_r <= 1'b0;
      end
      if (state_r == SSC_SHIFT && sample_ev && rx_ok_r && rx_complete_r
          && bit_cnt_r == `SSC_OVR_BIT) begin
        overrun_flag_r <= 1'b1;
      end else if (!ctlb_r[`SSC_CB_RE]) begin
        overrun_flag_r <= 1'b0;
      end
    end
  end

  // AXI read path
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 8'h00;
    case (s_axi_araddr[7:0])
      `SSC_A_TXBUF: rd_word = 8'h00;
      `SSC_A_RXBUF: rd_word = rx_buffer_r;
      `SSC_A_BRG:   rd_word = bit_rate_divisor_r;
      `SSC_A_MODE:  rd_word = serial_mode_config_r;
      `SSC_A_CTLA:  rd_word = {ctla_r[7:4], tx_shift_empty_r, ctla_r[2:0]};
      `SSC_A_CTLB:  rd_word = {ctlb_r[7:4], rx_complete_r, ctlb_r[2],
                               tx_buffer_empty_r, ctlb_r[0]};
      `SSC_A_SMR1:  rd_word = smr1_r;
      `SSC_A_SMR2:  rd_word = smr2_r;
      `SSC_A_SMR3:  rd_word = smr3_r;
      `SSC_A_SMR4:  rd_word = smr4_r;
      `SSC_A_PRESC: rd_word = {4'h0, prescale_setting_r};
      default:      rd_hit  = 1'b0;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SSC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_word};
        if (s_axi_araddr[7:0] == `SSC_A_RXBUF) begin
          // overrun flag in receive buffer word
          s_axi_rdata[`SSC_RB_OER] <= overrun_flag_r;
        end
        s_axi_rresp  <= rd_hit ? `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= '{clk_o: 1'b1, clk_oe: 1'b0, txd_o: 1'b1, txd_oe: 1'b1, rts_o: 1'b1};
    end else begin
      // open drain drives only the low level
      pin_out.clk_o  <= clk_int_r;
      pin_out.clk_oe <= !clock_source_dir && (!smr3_r[`SSC_SMR3_CLK_OUT_FORMAT_SEL] || !clk_int_r);
      pin_out.txd_o  <= txd_r;
      pin_out.txd_oe <= !ctla_r[`SSC_CA_NCH] || !txd_r;
      // RTS low when ready to receive
      pin_out.rts_o  <= ctla_r[`SSC_CA_CRD] || !ctla_r[`SSC_CA_CRS]
                        || !(rx_en && !rx_complete_r);
    end
  end
endmodule

// ---- ssc_consts.svh ----
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
`define SSC_A_TXBUF   8'h00
`define SSC_A_RXBUF   8'h04
`define SSC_A_BRG     8'h08
`define SSC_A_MODE    8'h0C
`define SSC_A_CTLA    8'h10
`define SSC_A_CTLB    8'h14
`define SSC_A_SMR1    8'h18
`define SSC_A_SMR2    8'h1C
`define SSC_A_SMR3    8'h20
`define SSC_A_SMR4    8'h24
`define SSC_A_PRESC   8'h28
`define SSC_A_EVT     8'h2C
`define SSC_MODE_CLOCK_SOURCE_DIR   3
`define SSC_CA_CLK_LO    0
`define SSC_CA_CRS       2
`define SSC_CA_TX_SHIFT_EMPTY     3
`define SSC_CA_CRD       4
`define SSC_CA_NCH       5
`define SSC_CA_EDGE_POLARITY_SEL     6
`define SSC_CA_BIT_ORDER_SEL     7
`define SSC_CB_TE        0
`define SSC_CB_TI        1
`define SSC_CB_RE        2
`define SSC_CB_RI        3
`define SSC_CB_IRS       4
`define SSC_CB_RRM       5
`define SSC_CB_LCH       6
`define SSC_SMR3_CLK_OUT_FORMAT_SEL    3
`define SSC_RB_OER       12
`define SSC_FRAME_BITS   4'h8
`define SSC_OVR_BIT      4'h6
`define SSC_RESP_OKAY    2'h0
`define SSC_RESP_SLVERR  2'h2
`define SSC_CA_RESET     8'h08
`define SSC_CB_RESET     8'h02
`endif

// ---- ssc_pkg.sv ----
package ssc_pkg;
  typedef struct packed {
    logic clk_o;
    logic clk_oe;
    logic txd_o;
    logic txd_oe;
    logic rts_o;
  } ssc_pin_out_t;
  typedef struct packed {
    logic clk_i;
    logic rxd_i;
    logic cts_i;
  } ssc_pin_in_t;
  typedef enum logic [1:0] {
    SSC_IDLE  = 2'b00,
    SSC_SHIFT = 2'b01,
    SSC_DONE  = 2'b10
  } ssc_state_t;
endpackage

// ---- ssc_rate_gen.sv ----
`timescale 1ns/100ps
`include "ssc_consts.svh"
// internal rate source: prescaler, source select, bit-rate divisor
module ssc_rate_gen
  import ssc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [3:0] prescale_setting,
  input  wire logic [1:0] count_source_sel,
  input  wire logic [7:0] bit_rate_divisor,
  output logic            half_tick
);
  logic [4:0] pre_cnt_r;
  logic       pre_tick;
  logic [2:0] f8_cnt_r;
  logic       src_tick;
  logic [7:0] div_cnt_r;
  // zero passes, n divides by 2n
  assign pre_tick = (prescale_setting == 4'h0) ? 1'b1
                  : (pre_cnt_r == {prescale_setting, 1'b0} - 5'h01);
  always_ff @(posedge aclk) begin
    if (!aresetn || pre_tick) begin
      pre_cnt_r <= 5'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 5'h01;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      f8_cnt_r <= 3'h0;
    end else begin
      f8_cnt_r <= f8_cnt_r + 3'h1;
    end
  end
  always_comb begin
    case (count_source_sel)
      2'h0: src_tick = 1'b1;
      2'h1: src_tick = (f8_cnt_r == 3'h7);
      2'h2: src_tick = pre_tick;
      default: src_tick = 1'b1;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= 8'h00;
      half_tick <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      if (src_tick) begin
        if (div_cnt_r >= bit_rate_divisor) begin
          div_cnt_r <= 8'h00;
          half_tick <= 1'b1;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end
endmodule

// ---- ssc_chk.sv ----
`timescale 1ns/100ps
`include "ssc_consts.svh"
module ssc_chk
  import ssc_pkg::*;
(
  input wire logic                  aclk,
  input wire logic                  aresetn,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire ssc_pkg::ssc_pin_out_t pin_out,
  input wire logic                  tx_int_pulse,
  input wire logic                  rx_int_pulse
);
  logic [2:0] quiet_r;
  logic [1:0] rx_d_r;
  logic       clk_q_r;
  logic [5:0] edge_cnt_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    quiet_r <= {quiet_r[1:0], s_axi_awvalid | s_axi_bvalid};
    rx_d_r  <= {rx_d_r[0], rx_int_pulse};
    clk_q_r <= pin_out.clk_o;
  end
  // clock transitions since last write or received frame
  always_ff @(posedge aclk) begin
    if (!aresetn || (|quiet_r) || rx_d_r[1]) begin
      edge_cnt_r <= 6'h00;
    end else if (pin_out.clk_oe && (pin_out.clk_o != clk_q_r)) begin
      edge_cnt_r <= edge_cnt_r + 6'h01;
    end
  end
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  chk_arready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == `SSC_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read returns data");
  chk_eight_pulses: assert property (rx_int_pulse |-> ##[0:1] (edge_cnt_r == 6'h10))
    else $error("frame without eight clock pulses");
  chk_clk_quiet_after: assert property (rx_int_pulse |=> $stable(pin_out.clk_o) [*2])
    else $error("clock moves after frame");
  chk_rx_pulse_single: assert property (rx_int_pulse |=> !rx_int_pulse)
    else $error("receive pulse too long");
  chk_tx_pulse_single: assert property (tx_int_pulse |=> !tx_int_pulse)
    else $error("transmit pulse too long");
  cov_rx_frame: cover property (rx_int_pulse);
  cov_tx_event: cover property (tx_int_pulse);
  cov_slverr: cover property (s_axi_rvalid && s_axi_rresp == `SSC_RESP_SLVERR);
endmodule
bind ssc_channel ssc_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .pin_out(pin_out), .tx_int_pulse(tx_int_pulse),
  .rx_int_pulse(rx_int_pulse)
);

// ---- ssc_peer.sv ----
`timescale 1ns/100ps
module ssc_peer (
  input  wire logic       line_clk,
  input  wire logic       txd_line,
  input  wire logic       pol,
  input  wire logic       msb,
  input  wire logic       clr_n,
  input  wire logic [7:0] send_byte,
  output logic            rxd,
  output logic            clk_idle,
  output logic [7:0]      got_byte,
  output logic [31:0]     gap_ns
);
  int    cnt;
  longint last_t;
  function automatic int idx(input int k);
    return msb ? 7 - k : k;
  endfunction
  assign clk_idle = ~pol;
  always @(line_clk or negedge clr_n) begin
    if (!clr_n) begin
      cnt = 0;
      rxd = send_byte[idx(0)];
    end else begin
      gap_ns = 32'($time - last_t);
      last_t = $time;
      if (line_clk === ~pol) begin
        got_byte[idx(cnt)] = txd_line;
        cnt = (cnt + 1) % 8;
        // rxd flipped after the frame
        if (cnt == 0) rxd = ~rxd;
      end else begin
        rxd = send_byte[idx(cnt)];
      end
    end
  end
endmodule

// ---- tb_top.sv ----
`timescale 1ns/100ps
`include "ssc_consts.svh"
module tb_top;
  import ssc_pkg::*;
  typedef struct packed {
    logic [33:0] val;
    logic [33:0] msk;
  } ssc_exp_t;
  logic         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cts_n, clr_n;
  logic         awready, wready, bvalid, arready, rvalid, pol, msb, rxd, clk_idle, txp, rxp;
  logic [31:0]  awaddr, wdata, araddr, rdata, gap;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, sel;
  logic [7:0]   sendb, gotb;
  logic [33:0]  got;
  ssc_exp_t     e;
  ssc_exp_t     exp_q[$];
  ssc_pin_in_t  pin_in;
  ssc_pin_out_t pin_out;
  int           fail_count, checked, ntx, nrx;
  assign pin_in = {pin_out.clk_oe ? pin_out.clk_o : clk_idle, rxd, cts_n};
  ssc_channel uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out), .tx_int_pulse(txp),
    .rx_int_pulse(rxp));
  ssc_peer peer (.line_clk(pin_in.clk_i), .txd_line(pin_out.txd_oe ? pin_out.txd_o : 1'b1),
    .pol(pol), .msb(msb), .clr_n(clr_n), .send_byte(sendb), .rxd(rxd), .clk_idle(clk_idle),
    .got_byte(gotb), .gap_ns(gap));
  always #10 aclk = ~aclk;
  task automatic note_fail(input string m);
    fail_count++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) note_fail($sformatf("got %h expected %h", g, x));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back('{val: {r, 32'h0}, msk: {2'h3, 32'h0}});
    @(posedge aclk);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    bready <= 1'b0;
    if (n >= 200) note_fail("write hangs");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic [1:0] r);
    int n;
    n = 0;
    exp_q.push_back('{val: {r, x}, msk: {2'h3, m}});
    @(posedge aclk);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    rready <= 1'b0;
    if (n >= 200) note_fail("read hangs");
  endtask
  task automatic wait_ev(input int t, input int r);
    int n;
    n = 0;
    while ((ntx < t || nrx < r) && n < 4000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 4000) note_fail("serial event missing");
    repeat (4) @(posedge aclk);
  endtask
  task automatic frame(input logic [7:0] txb, input logic inv, input logic [31:0] half);
    repeat (260) @(posedge aclk);
    sendb <= 8'($urandom);
    clr_n <= 1'b0;
    @(posedge aclk);
    clr_n <= 1'b1;
    wr(`SSC_A_TXBUF, txb, `SSC_RESP_OKAY);
    wait_ev(ntx + 1, nrx + 1);
    check({24'h0, gotb}, {24'h0, txb ^ {8{inv}}});
    rd(`SSC_A_RXBUF, {24'h0, sendb ^ {8{inv}}}, 32'h10FF, `SSC_RESP_OKAY);
    check(gap, half * 20);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    if (txp === 1'b1) ntx++;
    if (rxp === 1'b1) nrx++;
    if ((bvalid && bready) || (rvalid && rready)) begin
      got = bvalid ? {bresp, 32'h0} : {rresp, rdata};
      if (exp_q.size() == 0) begin
        note_fail("answer without request");
      end else begin
        e = exp_q.pop_front();
        checked++;
        if ((got & e.msk) !== (e.val & e.msk)) note_fail($sformatf("got %h wanted %h", got, e.val));
      end
    end
  end
  initial begin
    repeat (40000) @(posedge aclk);
    note_fail("watchdog expired");
    final_report();
  end
  initial begin
    logic [2:0] c;
    logic [3:0] p;
    int         r0;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cts_n, clr_n} = '0;
    {awaddr, wdata, araddr, pol, msb, sendb} = '0;
    wstrb = 4'hF;
    void'($urandom(32'h37B0));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    clr_n <= 1'b1;
    rd(`SSC_A_CTLA, 32'h08, 32'hFF, `SSC_RESP_OKAY);
    rd(`SSC_A_CTLB, 32'h02, 32'hFF, `SSC_RESP_OKAY);
    rd(8'h30, 32'h0, 32'hFFFFFFFF, `SSC_RESP_SLVERR);
    wr(8'h30, 8'h55, `SSC_RESP_SLVERR);
    wr(`SSC_A_BRG, 8'h03, `SSC_RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      c = 3'(i);
      sel = (i < 2) ? 2'(i) : 2'h2;
      p = (i == 3) ? 4'h1 : (i == 4) ? 4'hF : 4'h0;
      wr(`SSC_A_PRESC, {4'h0, p}, `SSC_RESP_OKAY);
      wr(`SSC_A_CTLA, {c[1], c[0], 4'h0, sel}, `SSC_RESP_OKAY);
      wr(`SSC_A_CTLB, {1'b0, c[2], 1'b0, c[0] | c[2], 4'h5}, `SSC_RESP_OKAY);
      pol <= c[0];
      msb <= c[1];
      frame(8'($urandom), c[2], 4 * ((sel == 2'h1) ? 8 : (sel == 2'h2 && p != 0) ? 2 * p : 1));
    end
    check({31'h0, pin_out.clk_oe}, 32'h1);
    cts_n <= 1'b1;
    wr(`SSC_A_TXBUF, 8'h3C, `SSC_RESP_OKAY);
    repeat (200) @(posedge aclk);
    rd(`SSC_A_CTLA, 32'h08, 32'h08, `SSC_RESP_OKAY);
    rd(`SSC_A_CTLB, 32'h00, 32'h02, `SSC_RESP_OKAY);
    cts_n <= 1'b0;
    wait_ev(ntx + 1, nrx + 1);
    r0 = nrx;
    wr(`SSC_A_TXBUF, 8'hC3, `SSC_RESP_OKAY);
    wait_ev(ntx + 1, 0);
    check(32'(nrx), 32'(r0));
    rd(`SSC_A_RXBUF, 32'h1000, 32'h1000, `SSC_RESP_OKAY);
    rd(`SSC_A_RXBUF, 32'h1000, 32'h1000, `SSC_RESP_OKAY);
    wr(`SSC_A_CTLB, 8'h51, `SSC_RESP_OKAY);
    wr(`SSC_A_CTLB, 8'h75, `SSC_RESP_OKAY);
    rd(`SSC_A_RXBUF, 32'h0000, 32'h1000, `SSC_RESP_OKAY);
    wait_ev(ntx + 1, nrx + 1);
    wr(`SSC_A_MODE, 8'h08, `SSC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({31'h0, pin_out.clk_oe}, 32'h0);
    wr(`SSC_A_CTLA, 8'h24, `SSC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({31'h0, pin_out.txd_oe}, 32'h0);
    check({31'h0, pin_out.rts_o}, 32'h1);
    rd(`SSC_A_RXBUF, 32'h0000, 32'h1000, `SSC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({31'h0, pin_out.rts_o}, 32'h0);
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule
